// ---- src/ccs_clock_sync.sv ----
// Converter clock selection and multi-device sync control with APB registers.
// Assumes pclk stands for the converter clock; strobes and sync are pins.
`timescale 1ns/1ps

// Behaviour
// - Core runs on converter clock, capture separate
// - Loop mode uses clock pins as reference
// - Path 0, powerdown 1 selects bypass
// - Path 1, powerdown 0 selects multiplying loop
// - Prescale code is binary divide 2..6
// - Six-bit coarse tune steers oscillator
// - M code is plain binary divide value
// - Pump code 01 single, 11 double
// - Loop derives output strobe from divider
// - Resync enable resets dividers on sync rise
// - No timing needed between sync and strobe
// - Loop mode needs no external strobe
// - Dual mode: write and read pointers independent
module ccs_clock_sync
  import ccs_pkg::*;
#(
  parameter int MDIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_in,
  input wire logic input_strobe,
  input wire logic output_strobe,
  output logic sample_clock_from_loop,
  output logic loop_powered,
  output logic [2:0] prescale_div,
  output logic [5:0] oscillator_coarse_tune,
  output logic [1:0] pump_current,
  output logic internal_output_strobe,
  output logic write_ptr_reset,
  output logic read_ptr_reset,
  output logic divider_align_pulse
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] general_control_reg_q;
  logic [31:0] loop_setup_reg_q;
  logic [31:0] oscillator_setup_reg_q;
  logic [31:0] sync_source_reg_q;
  logic [2:0] alarm_flags_reg_q;
  logic [31:0] prdata_d;
  logic [31:0] status_w;
  logic wr_en;
  logic addr_ok;
  ccs_loop_cfg_t cfg;
  ccs_mode_t mode;

  function automatic logic ccs_hit(input logic [7:0] a);
    return a == CCS_GENERAL_CONTROL_OFS || a == CCS_ALARM_FLAGS_OFS
        || a == CCS_LOOP_SETUP_OFS || a == CCS_OSCILLATOR_SETUP_OFS
        || a == CCS_SYNC_SOURCE_OFS || a == CCS_STATUS_OFS;
  endfunction : ccs_hit

  // A select field may name several sources; any one of them is enough.
  function automatic logic ccs_src_has(input logic [3:0] sel, input logic [3:0] src);
    return (sel & src) != 4'h0;
  endfunction : ccs_src_has

  assign addr_ok = ccs_hit(paddr);
  // Writes to unmapped offsets are dropped; the error answer is raised in setup.
  assign wr_en = psel && penable && pwrite && addr_ok;

  // Field by field, because bit 7 of the register is unused and the struct has no gap.
  always_comb begin
    cfg.path_sel = loop_setup_reg_q[CCS_LS_PATH_SEL_BIT];
    cfg.resync_ena = loop_setup_reg_q[CCS_LS_RESYNC_ENA_BIT];
    cfg.pump = loop_setup_reg_q[CCS_LS_PUMP_LSB +: 2];
    cfg.prescale = loop_setup_reg_q[CCS_LS_PRESCALE_LSB +: 3];
    cfg.m_div = loop_setup_reg_q[CCS_LS_MDIV_LSB +: 8];
  end

  // Both bits must agree; a mixed setting decodes to CCS_MODE_INVALID.
  always_comb begin
    unique case ({oscillator_setup_reg_q[CCS_OS_PWRDN_BIT], cfg.path_sel})
      2'b10: mode = CCS_MODE_BYPASS;
      2'b01: mode = CCS_MODE_LOOP;
      default: mode = CCS_MODE_INVALID;
    endcase
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states: the access phase completes in its first cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !ccs_hit(paddr);
    end
  end

  // Only implemented bits, and the unused bit 7 of the loop setup, are stored; the others read back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_control_reg_q <= CCS_GC_RESET;
      loop_setup_reg_q <= CCS_LS_RESET;
      oscillator_setup_reg_q <= CCS_OS_RESET;
      sync_source_reg_q <= CCS_SS_RESET;
    end else if (wr_en && pready) begin
      unique case (paddr)
        CCS_GENERAL_CONTROL_OFS: general_control_reg_q <= {30'h0, pwdata[1:0]};
        CCS_LOOP_SETUP_OFS: loop_setup_reg_q <= {16'h0, pwdata[15:0]};
        CCS_OSCILLATOR_SETUP_OFS: oscillator_setup_reg_q <= {25'h0, pwdata[6:0]};
        CCS_SYNC_SOURCE_OFS: sync_source_reg_q <= {20'h0, pwdata[11:0]};
        default: ;
      endcase
    end
  end

  assign status_w = {28'h0, internal_output_strobe, loop_powered,
                     sample_clock_from_loop, mode == CCS_MODE_INVALID};

  always_comb begin
    prdata_d = 32'h0;
    unique case (paddr)
      CCS_GENERAL_CONTROL_OFS: prdata_d = general_control_reg_q;
      CCS_ALARM_FLAGS_OFS: prdata_d = {29'h0, alarm_flags_reg_q};
      CCS_LOOP_SETUP_OFS: prdata_d = loop_setup_reg_q;
      CCS_OSCILLATOR_SETUP_OFS: prdata_d = oscillator_setup_reg_q;
      CCS_SYNC_SOURCE_OFS: prdata_d = sync_source_reg_q;
      CCS_STATUS_OFS: prdata_d = status_w;
      default: prdata_d = 32'h0;
    endcase
  end

  // Read data is captured in setup, so it already stands in the access cycle.
  // Write setups leave it alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= prdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic sync_rise;
  logic input_strobe_rise;
  logic output_strobe_rise;

  // The pins come from other clock domains, so no timing relation is assumed.
  // The level outputs stay open; this block acts on rising edges only.
  ccs_sync3 u_sync_s (
    .clk(pclk),
    .rst_n(presetn),
    .din(sync_in),
    .level(),
    .rise(sync_rise)
  );
  ccs_sync3 u_sync_i (
    .clk(pclk),
    .rst_n(presetn),
    .din(input_strobe),
    .level(),
    .rise(input_strobe_rise)
  );
  ccs_sync3 u_sync_o (
    .clk(pclk),
    .rst_n(presetn),
    .din(output_strobe),
    .level(),
    .rise(output_strobe_rise)
  );

  // ---------------------------------------------------------------
  // Clock path selection
  // ---------------------------------------------------------------
  logic loop_active;
  logic [2:0] prescale_d;

  // Out-of-range prescale codes clamp to the nearest legal divide.
  always_comb begin
    prescale_d = cfg.prescale;
    if (cfg.prescale < CCS_PRESCALE_MIN) begin
      prescale_d = CCS_PRESCALE_MIN;
    end else if (cfg.prescale > CCS_PRESCALE_MAX) begin
      prescale_d = CCS_PRESCALE_MAX;
    end
  end

  // A conflicting setting changes nothing here, so the sample clock never
  // switches over to a source that is asleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_clock_from_loop <= 1'b0;
      loop_powered <= 1'b0;
    end else begin
      unique case (mode)
        CCS_MODE_BYPASS: begin
          sample_clock_from_loop <= 1'b0;
          loop_powered <= 1'b0;
        end
        CCS_MODE_LOOP: begin
          sample_clock_from_loop <= 1'b1;
          loop_powered <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  assign loop_active = sample_clock_from_loop && loop_powered;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_div <= CCS_PRESCALE_MIN;
      oscillator_coarse_tune <= 6'h00;
      pump_current <= CCS_PUMP_SINGLE;
    end else begin
      prescale_div <= prescale_d;
      oscillator_coarse_tune <= oscillator_setup_reg_q[CCS_OS_TUNE_LSB +: 6];
      // An unknown pump code leaves the last valid current in place.
      if (cfg.pump == CCS_PUMP_SINGLE || cfg.pump == CCS_PUMP_DOUBLE) begin
        pump_current <= cfg.pump;
      end
    end
  end

  // ---------------------------------------------------------------
  // Feedback divider and internal strobe
  // ---------------------------------------------------------------
  logic n_reset_q;
  logic n_tick;

  // A sync rise clears the divider for one cycle when enabled.
  // The extra flop puts the clear a fixed edge after the detected rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_reset_q <= 1'b0;
    end else begin
      n_reset_q <= cfg.resync_ena && sync_rise;
    end
  end

  ccs_div #(.W(MDIV_W)) u_ndiv (
    .clk(pclk),
    .rst_n(presetn),
    .run(loop_active),
    .clear(n_reset_q),
    .div_val(cfg.m_div),
    .tick(n_tick)
  );

  // In bypass the synchronised pin strobe takes the place of the divider tick.
  // One more flop keeps the strobe output registered like every other port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_output_strobe <= 1'b0;
    end else begin
      internal_output_strobe <= loop_active ? n_tick : output_strobe_rise;
    end
  end

  // ---------------------------------------------------------------
  // Pointer and divider alignment
  // ---------------------------------------------------------------
  logic [3:0] in_sel;
  logic [3:0] out_sel;
  logic [3:0] align_sel;
  logic fifo_ena;
  logic out_event;

  assign in_sel = sync_source_reg_q[CCS_SS_FIFOIN_LSB +: 4];
  assign out_sel = sync_source_reg_q[CCS_SS_FIFOOUT_LSB +: 4];
  assign align_sel = sync_source_reg_q[CCS_SS_ALIGN_SRC_LSB +: 4];
  assign fifo_ena = general_control_reg_q[CCS_GC_FIFO_ENA_BIT];
  // With the loop active the divider tick stands in for the pin.
  assign out_event = loop_active ? n_tick : output_strobe_rise;

  // A cleared FIFO enable silences both pointer resets.
  // Several selected sources simply combine; one is picked in normal use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_ptr_reset <= 1'b0;
      read_ptr_reset <= 1'b0;
      divider_align_pulse <= 1'b0;
    end else begin
      write_ptr_reset <= fifo_ena && ((ccs_src_has(in_sel, CCS_SRC_SYNC) && sync_rise)
          || (ccs_src_has(in_sel, CCS_SRC_INPUT_STROBE) && input_strobe_rise));
      read_ptr_reset <= fifo_ena && ((ccs_src_has(out_sel, CCS_SRC_OUTPUT_STROBE) && out_event)
          || (ccs_src_has(out_sel, CCS_SRC_SYNC) && sync_rise)
          || (ccs_src_has(out_sel, CCS_SRC_INPUT_STROBE) && input_strobe_rise));
      divider_align_pulse <= general_control_reg_q[CCS_GC_DIV_ALIGN_ENA_BIT]
          && ((ccs_src_has(align_sel, CCS_SRC_OUTPUT_STROBE) && out_event)
          || (ccs_src_has(align_sel, CCS_SRC_SYNC) && sync_rise)
          || (ccs_src_has(align_sel, CCS_SRC_INPUT_STROBE) && input_strobe_rise));
    end
  end

  // ---------------------------------------------------------------
  // Alarm flags
  // ---------------------------------------------------------------
  // Sticky: bit0 mode conflict, bit1 sync seen, bit2 strobe seen.
  // Write one clears, but a new event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_flags_reg_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en && pready && paddr == CCS_ALARM_FLAGS_OFS && pwdata[i]) begin
          alarm_flags_reg_q[i] <= 1'b0;
        end
      end
      if (mode == CCS_MODE_INVALID) begin
        alarm_flags_reg_q[0] <= 1'b1;
      end
      if (sync_rise) begin
        alarm_flags_reg_q[1] <= 1'b1;
      end
      if (output_strobe_rise) begin
        alarm_flags_reg_q[2] <= 1'b1;
      end
    end
  end

endmodule : ccs_clock_sync

// ---- src/ccs_pkg.sv ----
// Package for the converter clock selection and multi-device sync block.
// Assumes a 10 MHz APB clock; all register offsets are byte addresses.
package ccs_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CCS_GENERAL_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CCS_ALARM_FLAGS_OFS = 8'h04;
  localparam logic [7:0] CCS_LOOP_SETUP_OFS = 8'h08;
  localparam logic [7:0] CCS_OSCILLATOR_SETUP_OFS = 8'h0C;
  localparam logic [7:0] CCS_SYNC_SOURCE_OFS = 8'h10;
  localparam logic [7:0] CCS_STATUS_OFS = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CCS_GC_FIFO_ENA_BIT = 0;
  localparam int CCS_GC_DIV_ALIGN_ENA_BIT = 1;
  localparam int CCS_LS_PATH_SEL_BIT = 0;
  localparam int CCS_LS_RESYNC_ENA_BIT = 1;
  localparam int CCS_LS_PUMP_LSB = 2;
  localparam int CCS_LS_PRESCALE_LSB = 4;
  localparam int CCS_LS_MDIV_LSB = 8;
  localparam int CCS_OS_PWRDN_BIT = 0;
  localparam int CCS_OS_TUNE_LSB = 1;
  localparam int CCS_SS_FIFOOUT_LSB = 0;
  localparam int CCS_SS_FIFOIN_LSB = 4;
  localparam int CCS_SS_ALIGN_SRC_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CCS_GC_RESET = 32'h0000_0003;
  localparam logic [31:0] CCS_LS_RESET = 32'h0000_0424;
  localparam logic [31:0] CCS_OS_RESET = 32'h0000_0001;
  localparam logic [31:0] CCS_SS_RESET = 32'h0000_0444;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] CCS_SRC_SYNC = 4'h1;
  localparam logic [3:0] CCS_SRC_INPUT_STROBE = 4'h2;
  localparam logic [3:0] CCS_SRC_OUTPUT_STROBE = 4'h4;
  localparam logic [1:0] CCS_PUMP_SINGLE = 2'h1;
  localparam logic [1:0] CCS_PUMP_DOUBLE = 2'h3;
  localparam logic [2:0] CCS_PRESCALE_MIN = 3'h2;
  localparam logic [2:0] CCS_PRESCALE_MAX = 3'h6;

  typedef enum logic [1:0] {
    CCS_MODE_BYPASS = 2'b00,
    CCS_MODE_LOOP = 2'b01,
    CCS_MODE_INVALID = 2'b11
  } ccs_mode_t;

  typedef struct packed {
    logic [7:0] m_div;
    logic [2:0] prescale;
    logic [1:0] pump;
    logic resync_ena;
    logic path_sel;
  } ccs_loop_cfg_t;

endpackage : ccs_pkg

// ---- src/ccs_sync3.sv ----
// Three-stage synchroniser with agreement-based change detection.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module ccs_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic level,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Only the second stage reads the first, to keep metastability contained.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end

  assign rise = (s2_q == s3_q) && s3_q && !level;
endmodule : ccs_sync3

// ---- src/ccs_div.sv ----
// Programmable divider producing a one-cycle strobe every div_val cycles.
// Assumes div_val of zero or one means divide by one.
`timescale 1ns/1ps
module ccs_div #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear,
  input wire logic [W-1:0] div_val,
  output logic tick
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (clear || !run) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q + W'(1) >= div_val) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick <= 1'b0;
    end
  end
endmodule : ccs_div

// ---- verif/ccs_pin_model.sv ----
// Far-side model: clock distributor and data source driving the sync pins.
// Assumes pins idle low and change only just after a rising pclk edge.
`timescale 1ns/1ps
module ccs_pin_model (
  input wire logic pclk,
  output logic [2:0] pins
);
  // Index 0 is sync, 1 is the input strobe, 2 is the output strobe.
  initial pins = 3'h0;

  // Pins move on pclk because strobe and clock come from one domain.
  task automatic up(input int i);
    @(posedge pclk);
    pins[i] <= 1'b1;
  endtask : up

  // Callers hold a pin for several cycles so the synchroniser can agree.
  task automatic down(input int i);
    @(posedge pclk);
    pins[i] <= 1'b0;
  endtask : down
endmodule : ccs_pin_model

// ---- verif/ccs_clock_sync_assertions.sv ----
// Checker for the clock selection block: bus timing and control outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module ccs_clock_sync_chk
  import ccs_pkg::*;
#(
  parameter int MDIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_in,
  input wire logic input_strobe,
  input wire logic sample_clock_from_loop,
  input wire logic loop_powered,
  input wire logic [2:0] prescale_div,
  input wire logic [5:0] oscillator_coarse_tune,
  input wire logic [1:0] pump_current,
  input wire logic write_ptr_reset,
  input wire logic read_ptr_reset
);
  logic [5:0] tune_q;
  logic [1:0] pins_q;
  logic [3:0] since_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_commit(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tune_q <= 6'h00;
    else if (psel && penable && pready && pwrite && paddr == CCS_OSCILLATOR_SETUP_OFS)
      tune_q <= pwdata[6:1];
  end

  // Saturating age of the last sync or input strobe rise seen at the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 2'b00;
      since_q <= 4'hF;
    end else begin
      pins_q <= {sync_in, input_strobe};
      if (|({sync_in, input_strobe} & ~pins_q)) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
  end

  a_ready_zero_wait: assert property (s_setup |=> pready)
    else $error("pready missing in access cycle");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_loop_needs_power: assert property (sample_clock_from_loop |-> loop_powered)
    else $error("loop clock selected while asleep");
  a_prescale_legal: assert property (prescale_div inside {[3'h2:3'h6]})
    else $error("prescale out of range");
  a_pump_follows: assert property (s_commit(CCS_LOOP_SETUP_OFS) ##0 pwdata[3:2] == 2'h3
    |-> ##[1:2] pump_current == CCS_PUMP_DOUBLE)
    else $error("double pump not applied");
  a_tune_follows: assert property (s_commit(CCS_OSCILLATOR_SETUP_OFS)
    |-> ##[1:2] oscillator_coarse_tune == tune_q)
    else $error("coarse tune not applied");
  a_wptr_one_pulse: assert property (write_ptr_reset |=> !write_ptr_reset)
    else $error("write pointer reset too long");
  a_wptr_has_cause: assert property (write_ptr_reset |-> since_q <= 4'h7)
    else $error("write pointer reset without pin rise");
  a_rptr_one_pulse: assert property (read_ptr_reset |=> !read_ptr_reset)
    else $error("read pointer reset too long");
endmodule : ccs_clock_sync_chk

bind ccs_clock_sync ccs_clock_sync_chk #(.MDIV_W(MDIV_W)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .sync_in, .input_strobe, .sample_clock_from_loop, .loop_powered, .prescale_div,
  .oscillator_coarse_tune, .pump_current, .write_ptr_reset, .read_ptr_reset
);

// ---- verif/tb.sv ----
// Self-checking bench: APB register tasks plus sync pin pulses.
// Assumes zero-wait APB and pins driven by the far-side model.
`timescale 1ns/1ps
module tb;
  import ccs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sample_clock_from_loop, loop_powered, internal_output_strobe;
  logic write_ptr_reset, read_ptr_reset, divider_align_pulse;
  logic [2:0] prescale_div, pins;
  logic [5:0] oscillator_coarse_tune;
  logic [1:0] pump_current;
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [31:0] rv[6] = '{32'h3, 32'h0, 32'h424, 32'h1, 32'h444, 32'h0};
  int err_count = 0, checks = 0, n, d[2], mv[2] = '{4, 8}, cnt[4] = '{0, 0, 0, 0};

  always #50 pclk = ~pclk;

  ccs_clock_sync #(.MDIV_W(8)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sync_in(pins[0]), .input_strobe(pins[1]), .output_strobe(pins[2]),
    .sample_clock_from_loop, .loop_powered, .prescale_div, .oscillator_coarse_tune,
    .pump_current, .internal_output_strobe, .write_ptr_reset, .read_ptr_reset,
    .divider_align_pulse
  );
  ccs_pin_model m_u (.pclk, .pins);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a wait that never answers.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Outputs are registered behind the bus, so let them settle before looking.
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
    repeat (3) @(posedge pclk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, m, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk(32'(e), 32'(ex));
  endtask : rd_chk

  task automatic wait_ios(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (internal_output_strobe !== 1'b1);
  endtask : wait_ios

  task automatic pin_test(input int idx, input int ex[4]);
    int c0[4];
    c0 = cnt;
    m_u.up(idx);
    repeat (8) @(posedge pclk);
    m_u.down(idx);
    repeat (8) @(posedge pclk);
    foreach (ex[i]) chk(32'(cnt[i] - c0[i]), 32'(ex[i]));
  endtask : pin_test

  always @(posedge pclk) begin
    if (write_ptr_reset === 1'b1) cnt[0] <= cnt[0] + 1;
    if (read_ptr_reset === 1'b1) cnt[1] <= cnt[1] + 1;
    if (divider_align_pulse === 1'b1) cnt[2] <= cnt[2] + 1;
    if (internal_output_strobe === 1'b1) cnt[3] <= cnt[3] + 1;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i], 32'hFFFFFFFF, i == 5);
    chk(32'({prescale_div, pump_current, sample_clock_from_loop, loop_powered}), 32'h24);
    wr(8'h10, 32'h414);
    wr(8'h08, 32'hC25);
    chk(32'(sample_clock_from_loop), 32'h0);
    rd_chk(8'h04, 32'h1, 32'h1, 1'b0);
    wr(8'h0C, 32'h54);
    chk(32'({sample_clock_from_loop, loop_powered, oscillator_coarse_tune}), 32'hEA);
    rd_chk(8'h14, 32'h6, 32'h6, 1'b0);
    // The conflict is gone now, so the clear is no longer overridden by the set.
    wr(8'h04, 32'h1);
    rd_chk(8'h04, 32'h0, 32'h1, 1'b0);
    for (int p = 2; p < 7; p++) begin
      wr(8'h08, 32'h1401 | 32'(p) << 4 | (p[0] ? 32'hC : 32'h4));
      chk(32'({prescale_div, pump_current}), 32'(p) << 2 | (p[0] ? 32'h3 : 32'h1));
    end
    wr(8'h08, 32'h469);
    chk(32'(pump_current), 32'h1);
    foreach (mv[i]) begin
      wr(8'h08, 32'h65 | 32'(mv[i]) << 8);
      wait_ios(n);
      wait_ios(n);
      chk(32'(n), 32'(mv[i]));
    end
    wr(8'h08, 32'h867);
    foreach (d[i]) begin
      wait_ios(n);
      repeat (i * 3) @(posedge pclk);
      m_u.up(0);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (!(internal_output_strobe === 1'b1 && n >= 7));
      d[i] = n;
      m_u.down(0);
      repeat (4) @(posedge pclk);
    end
    chk(32'(d[1]), 32'(d[0]));
    wr(8'h08, 32'h865);
    wr(8'h08, 32'h424);
    wr(8'h0C, 32'h1);
    chk(32'({sample_clock_from_loop, loop_powered}), 32'h0);
    pin_test(0, '{1, 0, 0, 0});
    pin_test(2, '{0, 1, 1, 1});
    wr(8'h10, 32'h424);
    pin_test(1, '{1, 0, 0, 0});
    wr(8'h00, 32'h1);
    pin_test(2, '{0, 1, 0, 1});
    finish_test();
  end
endmodule : tb
